// ---- hw/led_pkg.sv ----
// Constants, encodings and pattern helpers of the indicator LED driver.
// Assumes a single 100 MHz clock shared by every module that imports it.
package led_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Pattern phases in milliseconds
  localparam int FLICK_MS = 50;
  localparam int BLINK_MS = 200;
  localparam int FLASH_MS = 200;
  localparam int PAUSE_MS = 1000;
  localparam int MS_W     = 11;

  // Register byte addresses
  localparam logic [3:0] ADDR_STATE  = 4'h0;
  localparam logic [3:0] ADDR_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_ERR    = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // State register fields
  localparam int STATE_LSB  = 0;
  localparam int CHANGE_BIT = 4;
  // Control register fields
  localparam int BOOT_DONE_BIT = 0;
  localparam int FW_DL_BIT     = 1;
  // Error register fields
  localparam int PDI_WDT_BIT = 0;
  localparam int CFG_ERR_BIT = 1;
  localparam int APP_WDT_BIT = 2;
  // Status register fields
  localparam int ST_GREEN_BIT   = 0;
  localparam int ST_RED_BIT     = 1;
  localparam int ST_IN_LED_BIT  = 2;
  localparam int ST_OUT_LED_BIT = 3;
  localparam int ST_IN_LINK_BIT = 4;
  localparam int ST_OUT_LNK_BIT = 5;
  localparam int ST_SDA_BIT     = 6;
  localparam int ST_RPAT_LSB    = 8;

  // Communication state codes
  localparam logic [3:0] AL_INIT   = 4'h1;
  localparam logic [3:0] AL_PREOP  = 4'h2;
  localparam logic [3:0] AL_BOOT   = 4'h3;
  localparam logic [3:0] AL_SAFEOP = 4'h4;
  localparam logic [3:0] AL_OP     = 4'h8;

  // Reset values
  localparam logic [3:0] STATE_RST  = AL_INIT;
  localparam logic       CHANGE_RST = 1'b0;

  typedef enum logic [2:0] {
    PAT_OFF, PAT_ON, PAT_FLICKER, PAT_BLINK, PAT_SINGLE, PAT_DOUBLE
  } pattern_e;

  function automatic logic [MS_W-1:0] pat_period(input pattern_e p);
    case (p)
      PAT_FLICKER: pat_period = MS_W'(2 * FLICK_MS);
      PAT_BLINK:   pat_period = MS_W'(2 * BLINK_MS);
      PAT_SINGLE:  pat_period = MS_W'(FLASH_MS + PAUSE_MS);
      PAT_DOUBLE:  pat_period = MS_W'(3 * FLASH_MS + PAUSE_MS);
      default:     pat_period = MS_W'(1);
    endcase
  endfunction : pat_period

  function automatic logic pat_lit(input pattern_e p,
                                   input logic [MS_W-1:0] ms);
    case (p)
      PAT_ON:      pat_lit = 1'b1;
      PAT_FLICKER: pat_lit = ms < MS_W'(FLICK_MS);
      PAT_BLINK:   pat_lit = ms < MS_W'(BLINK_MS);
      PAT_SINGLE:  pat_lit = ms < MS_W'(FLASH_MS);
      PAT_DOUBLE:  pat_lit = (ms < MS_W'(FLASH_MS)) ||
                             ((ms >= MS_W'(2 * FLASH_MS)) &&
                              (ms < MS_W'(3 * FLASH_MS)));
      default:     pat_lit = 1'b0;
    endcase
  endfunction : pat_lit

endpackage : led_pkg

// ---- hw/led_tick_if.sv ----
// Time base signals shared between the divider and the LED logic.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
interface led_tick_if;
  logic tick_ms;
  logic flicker;
  modport source (output tick_ms, output flicker);
  modport sink   (input  tick_ms, input  flicker);
endinterface : led_tick_if

// ---- hw/led_timebase.sv ----
// Divider making a one-cycle millisecond enable and a free 10 Hz square.
// Assumes clk at the rate behind TICK_CYCLES.
`timescale 1ns/1ns
module led_timebase
  import led_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
) (
  input  wire logic    clk,
  input  wire logic    sys_rst,
  led_tick_if.source   tb
);
  localparam int CW = $clog2(TICKS + 1);

  typedef struct packed {
    logic [CW-1:0]   cnt;
    logic [MS_W-1:0] ms;
    logic            tick;
    logic            flick;
  } tb_s;

  tb_s s_q;
  tb_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == CW'(TICKS - 1)) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
      if (s_q.ms == MS_W'(FLICK_MS - 1)) begin
        s_d.ms    = '0;
        s_d.flick = ~s_q.flick;
      end else begin
        s_d.ms = s_q.ms + MS_W'(1);
      end
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tb.tick_ms = s_q.tick;
  assign tb.flicker = s_q.flick;
endmodule : led_timebase

// ---- hw/pin_sync.sv ----
// Three-stage synchroniser for pin levels; a change is taken once the
// second and third stages agree, which also rejects one-cycle glitches.
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.lvl[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.lvl;
endmodule : pin_sync

// ---- hw/network_indicator_led_driver.sv ----
// Network indicator LED driver: two port link LEDs, a green status LED
// and a red error LED carried on the two-wire serial data line.
// Assumes one 100 MHz clock, software on the plain register port, and
// link and activity levels arriving unsynchronised from the PHYs.
`timescale 1ns/1ns
module network_indicator_led_driver
  import led_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        inbound_port_link_valid,
  input  wire logic        inbound_port_activity,
  input  wire logic        outbound_port_link_valid,
  input  wire logic        outbound_port_activity,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe,
  output logic             inbound_port_link_led,
  output logic             outbound_port_link_led,
  output logic             status_led
);

  led_tick_if tbus ();

  led_timebase #(
    .TICKS (TICKS)
  ) u_timebase (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tb      (tbus.source)
  );

  logic [4:0] pins_raw;
  logic [4:0] pins;

  assign pins_raw = {serial_data_in,
                     outbound_port_activity, outbound_port_link_valid,
                     inbound_port_activity,  inbound_port_link_valid};

  pin_sync #(
    .W (5)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     (pins_raw),
    .level   (pins)
  );

  logic [1:0] link_ok;
  logic [1:0] act_now;
  logic       sda_lvl;

  assign link_ok = {pins[2], pins[0]};
  assign act_now = {pins[3], pins[1]};
  assign sda_lvl = pins[4];

  typedef struct packed {
    logic [3:0]      al_state;
    logic            change;
    logic            boot_done;
    logic            fw_dl;
    logic            pdi_wdt;
    logic            cfg_err;
    logic            app_wdt;
    logic [31:0]     rdata;
    pattern_e        g_pat;
    pattern_e        r_pat;
    logic [MS_W-1:0] g_ms;
    logic [MS_W-1:0] r_ms;
    logic            g_led;
    logic            r_led;
    logic [1:0]      act_seen;
    logic [1:0]      act_show;
    logic [1:0]      port_led;
    logic            flick_prev;
  } drv_s;

  drv_s s_q;
  drv_s s_d;

  // Steps a pattern phase counter; a newly chosen pattern starts lit
  function automatic logic [MS_W-1:0] next_ms(input pattern_e cur,
                                              input pattern_e nxt,
                                              input logic [MS_W-1:0] ms,
                                              input logic tick);
    if (nxt != cur) begin
      next_ms = '0;
    end else if (tick) begin
      if (ms >= pat_period(cur) - MS_W'(1)) begin
        next_ms = '0;
      end else begin
        next_ms = ms + MS_W'(1);
      end
    end else begin
      next_ms = ms;
    end
  endfunction : next_ms

  pattern_e g_sel;
  pattern_e r_sel;
  logic     boot_err;
  logic     auto_chg;
  logic     period_start;

  // Status LED pattern from the communication state
  always_comb begin
    if (!s_q.boot_done || s_q.fw_dl || s_q.al_state == AL_BOOT) begin
      g_sel = PAT_FLICKER;
    end else if (s_q.al_state == AL_OP) begin
      g_sel = PAT_ON;
    end else if (s_q.al_state == AL_PREOP) begin
      g_sel = PAT_BLINK;
    end else if (s_q.al_state == AL_SAFEOP) begin
      g_sel = PAT_SINGLE;
    end else begin
      g_sel = PAT_OFF;
    end
  end

  // Change flag in init means a boot failure, elsewhere a self-made move
  assign boot_err = s_q.change && (s_q.al_state == AL_INIT);
  assign auto_chg = s_q.change && (s_q.al_state != AL_INIT);

  // Most serious error wins so the LED never mixes two patterns
  always_comb begin
    if (s_q.pdi_wdt) begin
      r_sel = PAT_ON;
    end else if (boot_err) begin
      r_sel = PAT_FLICKER;
    end else if (s_q.app_wdt) begin
      r_sel = PAT_DOUBLE;
    end else if (s_q.cfg_err) begin
      r_sel = PAT_BLINK;
    end else if (auto_chg) begin
      r_sel = PAT_SINGLE;
    end else begin
      r_sel = PAT_OFF;
    end
  end

  assign period_start = tbus.flicker && !s_q.flick_prev;

  always_comb begin
    s_d            = s_q;
    s_d.rdata      = '0;
    s_d.flick_prev = tbus.flicker;

    // Register writes
    if (wr) begin
      if (addr == ADDR_STATE) begin
        s_d.al_state = wdata[STATE_LSB +: 4];
        s_d.change   = wdata[CHANGE_BIT];
      end else if (addr == ADDR_CTRL) begin
        s_d.boot_done = wdata[BOOT_DONE_BIT];
        s_d.fw_dl     = wdata[FW_DL_BIT];
      end else if (addr == ADDR_ERR) begin
        s_d.pdi_wdt = wdata[PDI_WDT_BIT];
        s_d.cfg_err = wdata[CFG_ERR_BIT];
        s_d.app_wdt = wdata[APP_WDT_BIT];
      end
    end

    // Register reads, data valid in the next cycle only
    if (rd) begin
      if (addr == ADDR_STATE) begin
        s_d.rdata[STATE_LSB +: 4] = s_q.al_state;
        s_d.rdata[CHANGE_BIT]     = s_q.change;
      end else if (addr == ADDR_CTRL) begin
        s_d.rdata[BOOT_DONE_BIT] = s_q.boot_done;
        s_d.rdata[FW_DL_BIT]     = s_q.fw_dl;
      end else if (addr == ADDR_ERR) begin
        s_d.rdata[PDI_WDT_BIT] = s_q.pdi_wdt;
        s_d.rdata[CFG_ERR_BIT] = s_q.cfg_err;
        s_d.rdata[APP_WDT_BIT] = s_q.app_wdt;
      end else if (addr == ADDR_STATUS) begin
        s_d.rdata[ST_GREEN_BIT]    = s_q.g_led;
        s_d.rdata[ST_RED_BIT]      = s_q.r_led;
        s_d.rdata[ST_IN_LED_BIT]   = s_q.port_led[0];
        s_d.rdata[ST_OUT_LED_BIT]  = s_q.port_led[1];
        s_d.rdata[ST_IN_LINK_BIT]  = link_ok[0];
        s_d.rdata[ST_OUT_LNK_BIT]  = link_ok[1];
        s_d.rdata[ST_SDA_BIT]      = sda_lvl;
        s_d.rdata[ST_RPAT_LSB +: 3] = s_q.r_pat;
      end
    end

    // Pattern sequencers share the millisecond enable
    s_d.g_ms  = next_ms(s_q.g_pat, g_sel, s_q.g_ms, tbus.tick_ms);
    s_d.r_ms  = next_ms(s_q.r_pat, r_sel, s_q.r_ms, tbus.tick_ms);
    s_d.g_pat = g_sel;
    s_d.r_pat = r_sel;
    s_d.g_led = pat_lit(s_d.g_pat, s_d.g_ms);
    s_d.r_led = pat_lit(s_d.r_pat, s_d.r_ms);

    // Traffic seen in one flicker period is shown through the next one,
    // so even a single short packet yields a visible flicker
    for (int p = 0; p < 2; p++) begin
      if (period_start) begin
        s_d.act_show[p] = s_q.act_seen[p] | act_now[p];
        s_d.act_seen[p] = act_now[p];
      end else if (act_now[p]) begin
        s_d.act_seen[p] = 1'b1;
      end
      s_d.port_led[p] = link_ok[p] &
                        (~s_d.act_show[p] | tbus.flicker);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q          <= '0;
      s_q.al_state <= STATE_RST;
      s_q.change   <= CHANGE_RST;
      s_q.g_pat    <= PAT_FLICKER;
      s_q.r_pat    <= PAT_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata                  = s_q.rdata;
  assign inbound_port_link_led  = s_q.port_led[0];
  assign outbound_port_link_led = s_q.port_led[1];
  assign status_led             = s_q.g_led;
  // Line pulled low through the LED while lit; released otherwise
  assign serial_data_out        = 1'b0;
  assign serial_data_oe         = s_q.r_led;

endmodule : network_indicator_led_driver

// ---- tb/led_driver_checker.sv ----
// Checker of the indicator LED driver, bound to its top module.
// Assumes registers change only through the register port.
`timescale 1ns/1ns
module led_driver_checker
  import led_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        inbound_port_link_valid,
  input wire logic        outbound_port_link_valid,
  input wire logic        serial_data_out,
  input wire logic        serial_data_oe,
  input wire logic        inbound_port_link_led,
  input wire logic        outbound_port_link_led,
  input wire logic        status_led
);
  // Two cycles of slack for the restart edge
  localparam int BLINK_MAX = BLINK_MS * TICKS + 2;
  logic [4:0]  state_q;
  logic [1:0]  ctrl_q;
  logic [2:0]  err_q;
  logic [2:0]  sel;
  logic [2:0]  sel_q;
  logic        oe_q;
  logic [31:0] run_q;
  logic        op_on;
  logic        init_on;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  assign op_on   = ctrl_q == 2'h1 && state_q[3:0] == AL_OP;
  assign init_on = ctrl_q == 2'h1 && state_q[3:0] == AL_INIT;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= {CHANGE_RST, STATE_RST};
      ctrl_q  <= 2'h0;
      err_q   <= 3'h0;
      sel_q   <= 3'h0;
      oe_q    <= 1'b0;
      run_q   <= 32'h0;
    end else begin
      if (wr && addr == ADDR_STATE) state_q <= wdata[4:0];
      if (wr && addr == ADDR_CTRL) ctrl_q <= wdata[1:0];
      if (wr && addr == ADDR_ERR) err_q <= wdata[2:0];
      sel_q <= sel;
      oe_q  <= serial_data_oe;
      run_q <= (serial_data_oe != oe_q || sel != sel_q) ? 32'h1
                                                         : run_q + 32'h1;
    end
  end

  // Red pattern expected from the shadow registers
  always_comb begin
    if (err_q[0]) sel = 3'h1;
    else if (state_q[4] && state_q[3:0] == AL_INIT) sel = 3'h2;
    else if (err_q[2]) sel = 3'h5;
    else if (err_q[1]) sel = 3'h3;
    else if (state_q[4]) sel = 3'h4;
    else sel = 3'h0;
  end

  AST_PDI_ON:
    assert property ($past(err_q[0]) |-> serial_data_oe)
    else $error("red led dark after interface watchdog");
  AST_OP_ON:
    assert property ($past(op_on) |-> status_led)
    else $error("green led dark in operational");
  AST_INIT_OFF:
    assert property ($past(init_on) |-> !status_led)
    else $error("green led lit in init");
  AST_IN_DARK:
    assert property (!inbound_port_link_valid [*6]
                     |=> !inbound_port_link_led)
    else $error("inbound led lit without link");
  AST_OUT_DARK:
    assert property (!outbound_port_link_valid [*6]
                     |=> !outbound_port_link_led)
    else $error("outbound led lit without link");
  AST_LOW_DRIVE:
    assert property (serial_data_oe |-> serial_data_out == 1'b0)
    else $error("serial data driven high");
  AST_RED_START:
    assert property (sel != sel_q && sel != 3'h0 |=> serial_data_oe)
    else $error("new error pattern not starting lit");
  AST_RED_IDLE:
    assert property (sel == 3'h0 && sel_q == 3'h0 |-> !serial_data_oe)
    else $error("red led lit without error");
  AST_BLINK_LEN:
    assert property (sel == 3'h3 && sel_q == 3'h3 |-> run_q <= BLINK_MAX)
    else $error("blink phase too long");
endmodule : led_driver_checker

bind network_indicator_led_driver led_driver_checker #(.TICKS(TICKS)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
  .inbound_port_link_valid(inbound_port_link_valid),
  .outbound_port_link_valid(outbound_port_link_valid),
  .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
  .inbound_port_link_led(inbound_port_link_led),
  .outbound_port_link_led(outbound_port_link_led),
  .status_led(status_led));

// ---- tb/led_connector.sv ----
// Connector side: pulled-up serial data line carrying the red LED.
// Assumes the driver only ever pulls the line low.
`timescale 1ns/1ns
module led_connector (
  input  wire logic serial_data_out,
  input  wire logic serial_data_oe,
  output logic      serial_line,
  output logic      red_lit
);
  // Released line rests at the pull-up level, never at the last value
  assign serial_line = serial_data_oe ? serial_data_out : 1'b1;
  assign red_lit     = !serial_line;
endmodule : led_connector

// ---- tb/test_network_indicator_led_driver.sv ----
// Testbench of the indicator LED driver: register tasks, pattern watches.
// Assumes TICKS of 10, so one millisecond lasts ten clock cycles.
`timescale 1ns/1ns
module test_network_indicator_led_driver
  import led_pkg::*;
;
  localparam int T = 10;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        in_link = 1'b0;
  logic        in_act = 1'b0;
  logic        out_link = 1'b0;
  logic        out_act = 1'b0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic        sda, sd_out, sd_oe, red_lit, in_led, out_led, status_led;
  int          n_fail = 0;
  int          num_checks = 0;
  int          c;
  logic [3:0]  ra[6] = '{ADDR_ERR, ADDR_ERR, ADDR_ERR, ADDR_ERR,
                         ADDR_STATE, ADDR_STATE};
  int          rv[6] = '{2, 6, 7, 0, 'h14, 'h11};
  int          rk[6] = '{3, 5, 1, 0, 4, 2};
  int          rm[6] = '{400, 1600, 20, 20, 1200, 100};
  logic [3:0]  gs[4] = '{AL_PREOP, AL_SAFEOP, AL_OP, AL_BOOT};
  int          gk[4] = '{3, 4, 1, 2};
  int          gm[4] = '{400, 1200, 20, 100};

  always #5 clk = ~clk;

  network_indicator_led_driver #(.TICKS(T)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .inbound_port_link_valid(in_link),
    .inbound_port_activity(in_act), .outbound_port_link_valid(out_link),
    .outbound_port_activity(out_act), .serial_data_in(sda),
    .serial_data_out(sd_out), .serial_data_oe(sd_oe),
    .inbound_port_link_led(in_led), .outbound_port_link_led(out_led),
    .status_led(status_led));

  led_connector conn_u (.serial_data_out(sd_out), .serial_data_oe(sd_oe),
                        .serial_line(sda), .red_lit(red_lit));

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input int d);
    addr  <= a;
    wdata <= 32'(d);
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
    #1 check("rdata after read", 32'h0, rdata);
    @(posedge clk);
  endtask : rd_reg

  function automatic bit exp_lit(input int kind, input int ms);
    case (kind)
      1: return 1'b1;
      2: return ms % 100 < 50;
      3: return ms % 400 < 200;
      4: return ms % 1200 < 200;
      5: return ms % 1600 < 200 || (ms % 1600 >= 400 && ms % 1600 < 600);
      default: return 1'b0;
    endcase
  endfunction : exp_lit

  // Samples mid-millisecond; skips points where the tick phase is unknown
  task automatic watch(input int which, input int kind, input int ms);
    logic led;
    for (int k = 1; k <= ms * T; k++) begin
      @(posedge clk);
      #1;
      led = which == 0 ? status_led : which == 1 ? red_lit :
            which == 2 ? in_led : out_led;
      if (k % T == 5 && exp_lit(kind, k / T) == exp_lit(kind, k / T + 1))
        check($sformatf("led %0d pattern %0d ms %0d", which, kind, k / T),
              32'(exp_lit(kind, k / T)), 32'(led));
    end
    @(posedge clk);
  endtask : watch

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    watch(0, 2, 200);
    rd_reg(ADDR_STATE, v);
    check("state reset", 32'h1, v);
    rd_reg(ADDR_CTRL, v);
    check("ctrl reset", 32'h0, v);
    wr_reg(4'h2, 'hFF);
    rd_reg(4'h2, v);
    check("unmapped", 32'h0, v);
    rd_reg(ADDR_ERR, v);
    check("err reset", 32'h0, v);
    $display("test registers done");
    wr_reg(ADDR_CTRL, 1);
    watch(0, 0, 20);
    for (int i = 0; i < 4; i++) begin
      wr_reg(ADDR_STATE, 32'(gs[i]));
      watch(0, gk[i], gm[i]);
    end
    wr_reg(ADDR_STATE, 32'(AL_OP));
    wr_reg(ADDR_CTRL, 3);
    watch(0, 2, 100);
    wr_reg(ADDR_CTRL, 1);
    $display("test status led done");
    for (int i = 0; i < 6; i++) begin
      wr_reg(ra[i], rv[i]);
      watch(1, rk[i], rm[i]);
    end
    rd_reg(ADDR_STATUS, v);
    check("red code", 32'h2, (v >> 8) & 32'h7);
    check("reserved", 32'h0, v & 32'hFFFF_F880);
    wr_reg(ADDR_ERR, 1);
    rd_reg(ADDR_STATUS, v);
    check("red priority", 32'h1, (v >> 8) & 32'h7);
    $display("test error led done");
    in_link <= 1'b1;
    repeat (10) @(posedge clk);
    watch(2, 1, 20);
    watch(3, 0, 20);
    in_act   <= 1'b1;
    out_link <= 1'b1;
    repeat (250 * T) @(posedge clk);
    c = 0;
    repeat (200 * T) begin
      @(posedge clk);
      #1 c += int'(in_led);
    end
    check("inbound flicker", 32'h1, 32'(c > 900 && c < 1100));
    watch(3, 1, 20);
    rd_reg(ADDR_STATUS, v);
    check("link levels", 32'h3, (v >> 4) & 32'h3);
    check("led levels", 32'h0A, v & 32'h4B);
    $display("test port leds done");
    end_of_test();
  end
endmodule : test_network_indicator_led_driver
